// ### irq_output_gating.sv
// Interrupt request output gating for serial, parallel and floppy sources, keyboard and pointer requests passed through ungated,
// with its configuration reached over an AXI4-Lite slave.
// Assumes all inputs are synchronous to mclk_i and sys_rst_i is the master reset.
`include "irq_gate_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module irq_output_gating (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic [3:0] ser0_flags_i,
    input wire logic [3:0] ser1_flags_i,
    input wire logic printer_ack_i,
    input wire logic fdc_exec_done_i,
    input wire logic fdc_nondma_ready_i,
    input wire logic kbd_port2_bit4_i,
    input wire logic kbd_port2_bit5_i,
    output logic serial_request_line_a_o,
    output logic serial_request_line_a_oe_o,
    output logic serial_request_line_b_o,
    output logic serial_request_line_b_oe_o,
    output logic parallel_request_line_a_o,
    output logic parallel_request_line_a_oe_o,
    input wire logic parallel_request_line_a_i,
    output logic parallel_request_line_b_o,
    output logic parallel_request_line_b_oe_o,
    input wire logic parallel_request_line_b_i,
    output logic floppy_request_out_o,
    output logic keyboard_request_out_o,
    output logic pointer_request_out_o
);
    irq_gate_pkg::top_state_t st_q;
    irq_gate_pkg::top_state_t st_d;
    logic fdc_src;
    logic fdc_gate;

    req_route_if ser0_route ();
    req_route_if ser1_route ();
    req_route_if par_route ();

    serial_chan_gate u_ser0 (
        .mask_i(st_q.ser_cfg0[`SER_MASK_HI:0]),
        .flags_i(ser0_flags_i),
        .gate_i(st_q.ser_cfg0[`SER_GATE_BIT]),
        .desig_i(irq_gate_pkg::ser_desig_t'(st_q.ser_cfg0[`SER_DESIG_HI:`SER_DESIG_LO])),
        .sel_en_i(st_q.ser_sel[`SER_SEL_EN_BIT]),
        .sel_line_a_i(st_q.ser_sel[`SER_SEL_CH0_BIT]),
        .route(ser0_route)
    );

    serial_chan_gate u_ser1 (
        .mask_i(st_q.ser_cfg1[`SER_MASK_HI:0]),
        .flags_i(ser1_flags_i),
        .gate_i(st_q.ser_cfg1[`SER_GATE_BIT]),
        .desig_i(irq_gate_pkg::ser_desig_t'(st_q.ser_cfg1[`SER_DESIG_HI:`SER_DESIG_LO])),
        .sel_en_i(st_q.ser_sel[`SER_SEL_EN_BIT]),
        .sel_line_a_i(st_q.ser_sel[`SER_SEL_CH1_BIT]),
        .route(ser1_route)
    );

    parallel_gate u_par (
        .ctl_irq_en_i(st_q.par_ctl[`PAR_CTL_IRQ_BIT]),
        .addr_ok_i(st_q.par_mode[`PAR_MODE_ADDR_BIT]),
        .ecp_en_i(st_q.par_mode[`PAR_MODE_ECP_BIT]),
        .conf_bidir_i(st_q.par_conf[`PAR_CONF_BIDIR_BIT]),
        .sel_en_i(st_q.par_sel[`PAR_SEL_EN_BIT]),
        .sel_line_b_i(st_q.par_sel[`PAR_SEL_LINE_BIT]),
        .dflt_line_a_i(st_q.par_mode[`PAR_MODE_DFLT_A_BIT]),
        .ack_i(printer_ack_i),
        .route(par_route)
    );

    always_comb begin
        fdc_src = fdc_exec_done_i | fdc_nondma_ready_i;
        // Native mode ignores the gate bit; the illegal mode code keeps the gate.
        if (st_q.fdc_mode[`FDC_MODE_HI:0] == irq_gate_pkg::HOST_NATIVE) begin
            fdc_gate = 1'b1;
        end else begin
            fdc_gate = st_q.fdc_digout[`DIGOUT_GATE_BIT];
        end
    end

    always_comb begin
        st_d = st_q;
        // Address and data may arrive in either order; each is held until both are in.
        if (s_axi_awvalid_i && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata_i[7:0];
            st_d.w_en = s_axi_wstrb_i[0];
        end
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `RESP_OKAY;
            unique case (st_q.aw_addr)
                `REG_SER0_CFG: if (st_q.w_en) st_d.ser_cfg0 = st_q.w_data;
                `REG_SER1_CFG: if (st_q.w_en) st_d.ser_cfg1 = st_q.w_data;
                `REG_SER_SEL: if (st_q.w_en) st_d.ser_sel = st_q.w_data;
                `REG_PAR_CTL: if (st_q.w_en) st_d.par_ctl = st_q.w_data;
                `REG_PAR_CONF: if (st_q.w_en) st_d.par_conf = st_q.w_data;
                `REG_PAR_SEL: if (st_q.w_en) st_d.par_sel = st_q.w_data;
                `REG_PAR_MODE: if (st_q.w_en) st_d.par_mode = st_q.w_data;
                `REG_FDC_MODE: if (st_q.w_en) st_d.fdc_mode = st_q.w_data;
                `REG_FDC_DIGOUT: if (st_q.w_en) st_d.fdc_digout = st_q.w_data;
                `REG_STATUS: st_d.bresp = `RESP_OKAY;
                default: st_d.bresp = `RESP_SLVERR;
            endcase
        end
        if (st_q.bvalid && s_axi_bready_i) begin
            st_d.bvalid = 1'b0;
        end
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready = !st_d.w_have && !st_d.bvalid;

        if (s_axi_arvalid_i && st_q.arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `RESP_OKAY;
            unique case (s_axi_araddr_i)
                `REG_SER0_CFG: st_d.rdata = {2'b00, st_q.ser_cfg0};
                `REG_SER1_CFG: st_d.rdata = {2'b00, st_q.ser_cfg1};
                `REG_SER_SEL: st_d.rdata = {2'b00, st_q.ser_sel};
                `REG_PAR_CTL: st_d.rdata = {2'b00, st_q.par_ctl};
                `REG_PAR_CONF: st_d.rdata = {2'b00, st_q.par_conf};
                `REG_PAR_SEL: st_d.rdata = {2'b00, st_q.par_sel};
                `REG_PAR_MODE: st_d.rdata = {2'b00, st_q.par_mode};
                `REG_FDC_MODE: st_d.rdata = {2'b00, st_q.fdc_mode};
                `REG_FDC_DIGOUT: st_d.rdata = {2'b00, st_q.fdc_digout};
                `REG_STATUS: st_d.rdata = {st_q.bidir, st_q.par_b_in, st_q.par_a_in,
                                           st_q.ptr, st_q.kbd, st_q.fdc,
                                           st_q.par_b, st_q.par_a,
                                           st_q.ser_b, st_q.ser_a};
                default: begin
                    st_d.rdata = 10'h000;
                    st_d.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready_i) begin
            st_d.rvalid = 1'b0;
        end
        st_d.arready = !st_d.rvalid;

        // One register stage from raw source to pin keeps each output a flip-flop
        // while holding the latency to a single clock.
        st_d.ser_a = ser0_route.a_req | ser1_route.a_req;
        st_d.ser_a_oe = ser0_route.a_oe | ser1_route.a_oe;
        st_d.ser_b = ser0_route.b_req | ser1_route.b_req;
        st_d.ser_b_oe = ser0_route.b_oe | ser1_route.b_oe;
        st_d.par_a = par_route.a_req;
        st_d.par_a_oe = par_route.a_oe;
        st_d.par_b = par_route.b_req;
        st_d.par_b_oe = par_route.b_oe;
        st_d.bidir = par_route.bidir;
        // The pins are only read back while they are allowed to act as inputs.
        st_d.par_a_in = par_route.bidir & parallel_request_line_a_i;
        st_d.par_b_in = par_route.bidir & parallel_request_line_b_i;
        st_d.fdc = fdc_src & fdc_gate;
        st_d.kbd = kbd_port2_bit4_i;
        st_d.ptr = kbd_port2_bit5_i;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready_o = st_q.awready;
    assign s_axi_wready_o = st_q.wready;
    assign s_axi_bvalid_o = st_q.bvalid;
    assign s_axi_bresp_o = st_q.bresp;
    assign s_axi_arready_o = st_q.arready;
    assign s_axi_rvalid_o = st_q.rvalid;
    assign s_axi_rdata_o = {22'h000000, st_q.rdata};
    assign s_axi_rresp_o = st_q.rresp;
    assign serial_request_line_a_o = st_q.ser_a;
    assign serial_request_line_a_oe_o = st_q.ser_a_oe;
    assign serial_request_line_b_o = st_q.ser_b;
    assign serial_request_line_b_oe_o = st_q.ser_b_oe;
    assign parallel_request_line_a_o = st_q.par_a;
    assign parallel_request_line_a_oe_o = st_q.par_a_oe;
    assign parallel_request_line_b_o = st_q.par_b;
    assign parallel_request_line_b_oe_o = st_q.par_b_oe;
    assign floppy_request_out_o = st_q.fdc;
    assign keyboard_request_out_o = st_q.kbd;
    assign pointer_request_out_o = st_q.ptr;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_read_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    sequence s_write_both_in;
        st_q.aw_have && st_q.w_have && !s_axi_bvalid_o;
    endsequence

    a_ser_floats: assert property (
        !st_q.ser_cfg0[`SER_GATE_BIT] && !st_q.ser_cfg1[`SER_GATE_BIT]
        |=> !serial_request_line_a_oe_o && !serial_request_line_b_oe_o
            && !serial_request_line_a_o && !serial_request_line_b_o)
        else $error("serial line driven with both gates low");

    a_ser_masked_low: assert property (
        (st_q.ser_cfg0[`SER_MASK_HI:0] == 4'h0) && (st_q.ser_cfg1[`SER_MASK_HI:0] == 4'h0)
        |=> !serial_request_line_a_o && !serial_request_line_b_o)
        else $error("serial request high with all sources masked");

    a_ser_desig_route: assert property (
        !st_q.ser_sel[`SER_SEL_EN_BIT] && !st_q.ser_cfg1[`SER_GATE_BIT]
        && st_q.ser_cfg0[`SER_GATE_BIT]
        && (st_q.ser_cfg0[`SER_DESIG_HI:`SER_DESIG_LO] == irq_gate_pkg::DESIG_FOURTH)
        && (|(st_q.ser_cfg0[`SER_MASK_HI:0] & ser0_flags_i))
        |=> serial_request_line_a_o && serial_request_line_a_oe_o && !serial_request_line_b_oe_o)
        else $error("fourth designation not routed to serial line a");

    a_ser_pending: assert property (
        serial_request_line_b_o |-> $past(
            (|(st_q.ser_cfg0[`SER_MASK_HI:0] & ser0_flags_i) && st_q.ser_cfg0[`SER_GATE_BIT])
            || (|(st_q.ser_cfg1[`SER_MASK_HI:0] & ser1_flags_i) && st_q.ser_cfg1[`SER_GATE_BIT])))
        else $error("serial line b high without an enabled source");

    a_ser_sel_route: assert property (
        st_q.ser_sel[`SER_SEL_EN_BIT] && st_q.ser_sel[`SER_SEL_CH0_BIT]
        && st_q.ser_sel[`SER_SEL_CH1_BIT]
        |=> !serial_request_line_b_oe_o && !serial_request_line_b_o)
        else $error("select mode ignored for serial line b");

    a_par_follows_ack: assert property (
        par_route.b_oe ##1 parallel_request_line_b_oe_o
        |-> parallel_request_line_b_o == $past(printer_ack_i))
        else $error("parallel line b does not follow acknowledge");

    a_par_float: assert property (
        !st_q.par_ctl[`PAR_CTL_IRQ_BIT] || !st_q.par_mode[`PAR_MODE_ADDR_BIT]
        |=> !parallel_request_line_a_oe_o && !parallel_request_line_b_oe_o)
        else $error("parallel line driven while not enabled");

    a_par_two_way: assert property (
        (parallel_request_line_a_oe_o || parallel_request_line_b_oe_o)
        && st_q.par_mode[`PAR_MODE_ECP_BIT] && st_q.par_conf[`PAR_CONF_BIDIR_BIT]
        && $stable(st_q.par_mode) && $stable(st_q.par_conf) && $stable(st_q.par_ctl)
        |-> st_q.bidir)
        else $error("two-way condition not reported");

    a_par_select: assert property (
        st_q.par_sel[`PAR_SEL_EN_BIT] && st_q.par_sel[`PAR_SEL_LINE_BIT]
        |=> !parallel_request_line_a_oe_o && !parallel_request_line_a_o)
        else $error("parallel select bit 5 not honoured");

    a_fdc_gated: assert property (
        (st_q.fdc_mode[`FDC_MODE_HI:0] != irq_gate_pkg::HOST_NATIVE)
        && !st_q.fdc_digout[`DIGOUT_GATE_BIT]
        |=> !floppy_request_out_o)
        else $error("floppy request passed a closed gate");

    a_fdc_native: assert property (
        (st_q.fdc_mode[`FDC_MODE_HI:0] == irq_gate_pkg::HOST_NATIVE)
        && (fdc_exec_done_i || fdc_nondma_ready_i)
        |=> floppy_request_out_o)
        else $error("floppy request missing in native mode");

    a_kbd_follow: assert property (
        ##1 keyboard_request_out_o == $past(kbd_port2_bit4_i))
        else $error("keyboard request does not follow port bit");

    a_ptr_follow: assert property (
        $rose(kbd_port2_bit5_i) |=> pointer_request_out_o [*1] ##0 $past(kbd_port2_bit5_i))
        else $error("pointer request does not follow port bit");

    a_ser_a_pending: assert property (
        serial_request_line_a_o |-> $past(
            (|(st_q.ser_cfg0[`SER_MASK_HI:0] & ser0_flags_i) && st_q.ser_cfg0[`SER_GATE_BIT])
            || (|(st_q.ser_cfg1[`SER_MASK_HI:0] & ser1_flags_i) && st_q.ser_cfg1[`SER_GATE_BIT])))
        else $error("serial line a high without an enabled source");

    a_ser_drive_gated: assert property (
        serial_request_line_a_oe_o || serial_request_line_b_oe_o
        |-> $past(st_q.ser_cfg0[`SER_GATE_BIT] || st_q.ser_cfg1[`SER_GATE_BIT]))
        else $error("serial line driven with no gate set");

    a_ser_serviced: assert property (
        (ser0_flags_i == 4'h0) && (ser1_flags_i == 4'h0)
        |=> !serial_request_line_a_o && !serial_request_line_b_o)
        else $error("serial request still high after sources serviced");

    a_par_a_ack: assert property (
        par_route.a_oe ##1 parallel_request_line_a_oe_o
        |-> parallel_request_line_a_o == $past(printer_ack_i))
        else $error("parallel line a does not follow acknowledge");

    a_fdc_source: assert property (
        floppy_request_out_o |-> $past(fdc_exec_done_i || fdc_nondma_ready_i))
        else $error("floppy request without a source");

    a_par_readback: assert property (
        !par_route.bidir |=> !st_q.par_a_in && !st_q.par_b_in)
        else $error("parallel pin read back outside two-way mode");

    a_axi_read_ans: assert property (
        s_read_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read not answered one clock after address");

    a_axi_write_ans: assert property (
        s_write_both_in |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
        else $error("write not answered after address and data");

endmodule // irq_output_gating
`default_nettype wire

// ### irq_gate_defines.svh
// Register offsets, field positions, reset values and bus answers of the interrupt gating block.
// Assumes it is included by bare name from files that need these constants.
`ifndef IRQ_GATE_DEFINES_SVH
`define IRQ_GATE_DEFINES_SVH

`define REG_SER0_CFG 8'h00
`define REG_SER1_CFG 8'h04
`define REG_SER_SEL 8'h08
`define REG_PAR_CTL 8'h0c
`define REG_PAR_CONF 8'h10
`define REG_PAR_SEL 8'h14
`define REG_PAR_MODE 8'h18
`define REG_FDC_MODE 8'h1c
`define REG_FDC_DIGOUT 8'h20
`define REG_STATUS 8'h24

`define SER_MASK_HI 3
`define SER_GATE_BIT 4
`define SER_DESIG_HI 6
`define SER_DESIG_LO 5
`define SER_SEL_EN_BIT 0
`define SER_SEL_CH0_BIT 2
`define SER_SEL_CH1_BIT 6
`define PAR_CTL_IRQ_BIT 4
`define PAR_CONF_BIDIR_BIT 6
`define PAR_SEL_EN_BIT 4
`define PAR_SEL_LINE_BIT 5
`define PAR_MODE_ADDR_BIT 0
`define PAR_MODE_ECP_BIT 1
`define PAR_MODE_DFLT_A_BIT 2
`define FDC_MODE_HI 1
`define DIGOUT_GATE_BIT 3

`define REG_RESET 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### irq_gate_pkg.sv
// Types shared by the interrupt gating block.
// Assumes no other package; users write irq_gate_pkg::name.
package irq_gate_pkg;

    typedef enum logic [1:0] {
        DESIG_FIRST = 2'b00,
        DESIG_SECOND = 2'b01,
        DESIG_THIRD = 2'b10,
        DESIG_FOURTH = 2'b11
    } ser_desig_t;

    typedef enum logic [1:0] {
        HOST_COMPAT_A = 2'b00,
        HOST_COMPAT_B = 2'b01,
        HOST_NATIVE = 2'b10
    } host_mode_t;

    typedef struct packed {
        logic [7:0] ser_cfg0;
        logic [7:0] ser_cfg1;
        logic [7:0] ser_sel;
        logic [7:0] par_ctl;
        logic [7:0] par_conf;
        logic [7:0] par_sel;
        logic [7:0] par_mode;
        logic [7:0] fdc_mode;
        logic [7:0] fdc_digout;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_en;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [9:0] rdata;
        logic ser_a;
        logic ser_a_oe;
        logic ser_b;
        logic ser_b_oe;
        logic par_a;
        logic par_a_oe;
        logic par_b;
        logic par_b_oe;
        logic par_a_in;
        logic par_b_in;
        logic bidir;
        logic fdc;
        logic kbd;
        logic ptr;
    } top_state_t;

endpackage

// ### req_route_if.sv
// Routed request terms from one gating unit to the output stage.
// Assumes one producer and one consumer in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
interface req_route_if;
    logic a_req;
    logic a_oe;
    logic b_req;
    logic b_oe;
    logic bidir;
    modport src (output a_req, output a_oe, output b_req, output b_oe, output bidir);
    modport dst (input a_req, input a_oe, input b_req, input b_oe, input bidir);
endinterface // req_route_if
`default_nettype wire

// ### serial_chan_gate.sv
// Combinational gating and line routing for one serial channel.
// Assumes its inputs come from registers or the flag pins and its result is registered by the caller.
`timescale 1ns/1ns
`default_nettype none
module serial_chan_gate (
    input wire logic [3:0] mask_i,
    input wire logic [3:0] flags_i,
    input wire logic gate_i,
    input wire irq_gate_pkg::ser_desig_t desig_i,
    input wire logic sel_en_i,
    input wire logic sel_line_a_i,
    req_route_if.src route
);
    logic use_a;
    logic pend;

    always_comb begin
        if (sel_en_i) begin
            use_a = sel_line_a_i;
        end else begin
            use_a = (desig_i == irq_gate_pkg::DESIG_SECOND) ||
                    (desig_i == irq_gate_pkg::DESIG_FOURTH);
        end
        pend = (|(mask_i & flags_i)) & gate_i;
        route.a_req = use_a & pend;
        route.b_req = ~use_a & pend;
        // A cleared gate floats the line instead of pulling it low.
        route.a_oe = use_a & gate_i;
        route.b_oe = ~use_a & gate_i;
        route.bidir = 1'b0;
    end
endmodule // serial_chan_gate
`default_nettype wire

// ### parallel_gate.sv
// Combinational enable, line choice and two-way condition for the parallel port request.
// Assumes its inputs come from registers or the acknowledge pin and the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module parallel_gate (
    input wire logic ctl_irq_en_i,
    input wire logic addr_ok_i,
    input wire logic ecp_en_i,
    input wire logic conf_bidir_i,
    input wire logic sel_en_i,
    input wire logic sel_line_b_i,
    input wire logic dflt_line_a_i,
    input wire logic ack_i,
    req_route_if.src route
);
    logic use_a;
    logic en;

    always_comb begin
        use_a = sel_en_i ? ~sel_line_b_i : dflt_line_a_i;
        en = ctl_irq_en_i & addr_ok_i;
        route.a_req = use_a & en & ack_i;
        route.b_req = ~use_a & en & ack_i;
        route.a_oe = use_a & en;
        route.b_oe = ~use_a & en;
        route.bidir = ecp_en_i & en & conf_bidir_i;
    end
endmodule // parallel_gate
`default_nettype wire

// ### irq_host_pic_model.sv
// Host interrupt controller inputs: the level that each request wire shows at the host.
// Assumes an enable is high while the device drives that wire.
`timescale 1ns/1ns
`default_nettype none
module irq_host_pic_model (
    input wire logic mclk_i,
    input wire logic [3:0] req_i,
    input wire logic [3:0] oe_i,
    output logic [3:0] line_o
);
    logic [3:0] float_q = 4'h0;
    // Released wires have no pull, so they toggle and never hold a stale level.
    always @(posedge mclk_i) float_q <= ~float_q;
    assign line_o = (req_i & oe_i) | (float_q & ~oe_i);
endmodule // irq_host_pic_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the interrupt output gating block.
// Assumes the package, header, design and host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [10:0] ser_m = 11'h033, par_m = 11'h0cc;
    logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0;
    logic ack = 1'h0, fex = 1'h0, fnd = 1'h0, k4 = 1'h0, k5 = 1'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdo, rdat;
    logic [3:0] f0 = 4'h0, f1 = 4'h0, req, oe, ln;
    logic awr, wrd, bv, arr, rv, fdo, kbo, pto;
    logic [1:0] br, rr;
    logic [3:0] ws = 4'h1;
    int err_total = 0, num_checks = 0, cyc = 0;
    wire logic [10:0] obs = {fdo, kbo, pto, req, oe};
    always #10 clk = ~clk;
    irq_output_gating dut (
        .mclk_i(clk), .sys_rst_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'h1), .s_axi_bresp_o(br),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(1'h1), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .ser0_flags_i(f0),
        .ser1_flags_i(f1), .printer_ack_i(ack), .fdc_exec_done_i(fex), .fdc_nondma_ready_i(fnd),
        .kbd_port2_bit4_i(k4), .kbd_port2_bit5_i(k5),
        .serial_request_line_a_o(req[0]), .serial_request_line_a_oe_o(oe[0]),
        .serial_request_line_b_o(req[1]), .serial_request_line_b_oe_o(oe[1]),
        .parallel_request_line_a_o(req[2]), .parallel_request_line_a_oe_o(oe[2]),
        .parallel_request_line_a_i(ln[2]), .parallel_request_line_b_o(req[3]),
        .parallel_request_line_b_oe_o(oe[3]), .parallel_request_line_b_i(ln[3]),
        .floppy_request_out_o(fdo), .keyboard_request_out_o(kbo), .pointer_request_out_o(pto)
    );
    irq_host_pic_model host (.mclk_i(clk), .req_i(req), .oe_i(oe), .line_o(ln));
    always @(posedge clk) cyc <= cyc + 1;
    initial begin
        wait (cyc == 5000);
        err_total++;
        close_out();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic see(input logic [10:0] msk, input logic [10:0] exp, input string m);
        repeat (2) @(posedge clk);
        chk({21'h0, obs & msk}, {21'h0, exp}, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
        end while (!bv);
        chk({30'h0, br}, {30'h0, er}, "write response");
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'h1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
        end while (!rv);
        rdat = {rdo[29:0], rr};
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_serial();
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {1'h0, i[1:0], 5'h12}, 2'h0);
            f0 <= 4'hd;
            see(ser_m, i[0] ? 11'h001 : 11'h002, "unmasked flags");
            f0 <= 4'h2;
            see(ser_m, i[0] ? 11'h011 : 11'h022, "route");
        end
        f0 <= 4'h0;
        see(ser_m, 11'h001, "serviced");
        f0 <= 4'h2;
        wr(8'h00, 8'h70, 2'h0);
        see(ser_m, 11'h001, "masked off");
        wr(8'h00, 8'h62, 2'h0);
        see(ser_m, 11'h000, "gate low");
    endtask
    task automatic t_select();
        wr(8'h00, 8'h12, 2'h0);
        wr(8'h04, 8'h12, 2'h0);
        f1 <= 4'h2;
        wr(8'h08, 8'h45, 2'h0);
        see(ser_m, 11'h011, "select line a");
    endtask
    task automatic t_par();
        wr(8'h0c, 8'h10, 2'h0);
        wr(8'h18, 8'h05, 2'h0);
        ack <= 1'h1;
        see(par_m, 11'h044, "ack on a");
        wr(8'h14, 8'h30, 2'h0);
        see(par_m, 11'h088, "select b");
        wr(8'h18, 8'h07, 2'h0);
        wr(8'h10, 8'h40, 2'h0);
        rd(8'h24);
        chk(rdat & 32'hc03, 32'hc00, "two-way on");
        ack <= 1'h0;
        see(par_m, 11'h008, "ack low");
        wr(8'h18, 8'h06, 2'h0);
        see(par_m, 11'h000, "address off");
        rd(8'h24);
        chk(rdat & 32'hc03, 32'h000, "two-way off");
    endtask
    task automatic t_fdc();
        fex <= 1'h1;
        for (int m = 0; m < 4; m++) begin
            wr(8'h1c, m[7:0], 2'h0);
            see(11'h400, (m == 2) ? 11'h400 : 11'h000, "mode gate");
        end
        wr(8'h1c, 8'h00, 2'h0);
        wr(8'h20, 8'h08, 2'h0);
        fex <= 1'h0;
        fnd <= 1'h1;
        see(11'h400, 11'h400, "non-dma gated on");
    endtask
    task automatic t_kbd();
        k4 <= 1'h1;
        @(posedge clk);
        chk({21'h0, obs & 11'h300}, 32'h0, "latency");
        @(posedge clk);
        chk({21'h0, obs & 11'h300}, 32'h200, "keyboard");
        k5 <= 1'h1;
        see(11'h300, 11'h300, "pointer");
    endtask
    task automatic t_bus();
        wr(8'h28, 8'h5a, 2'h2);
        rd(8'h28);
        chk(rdat, 32'h2, "unmapped read");
        ws <= 4'h0;
        wr(8'h20, 8'h00, 2'h0);
        ws <= 4'h1;
        rd(8'h20);
        chk(rdat, 32'h20, "strobe off keeps register");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        see(11'h7ff, 11'h000, "idle");
        t_serial();
        t_select();
        t_par();
        t_fdc();
        t_kbd();
        t_bus();
        close_out();
    end
endmodule // tb
`default_nettype wire
